// *** copper_test_pkg.sv ***
// constants for the copper test shadow register bank
`default_nettype none
package copper_test_pkg;
    localparam logic [15:0] SHADOW_ADDR    = 16'hFFF8;
    localparam logic [15:0] UNMAPPED_READ  = 16'h0000;
    localparam int          SEL_MSB        = 2;
    localparam int          SEL_LSB        = 0;
    localparam int          TEST_MSB       = 15;
    localparam int          TEST_LSB       = 3;
    localparam int          LOOP_BIT       = 15;
    localparam int          SWAP_BIT       = 4;
    localparam int          MISC_WE_BIT    = 15;
    localparam int          RSEL_MSB       = 14;
    localparam int          RSEL_LSB       = 12;
    localparam int          DATA_W         = 8;
    localparam logic [2:0]  CODE_AUX       = 3'h0;
    localparam logic [2:0]  CODE_PWR       = 3'h2;
    localparam logic [2:0]  CODE_TEST      = 3'h4;
    localparam logic [2:0]  CODE_MISC      = 3'h7;
    localparam logic [12:0] TEST_RESET     = 13'h0000;
    localparam logic [2:0]  RSEL_RESET     = 3'h0;
    localparam logic [8:0]  MISC_MID_READ  = 9'h000;
    localparam logic [12:0] OTHER_UPPER    = 13'h0000;

    // true for selector codes that name no shadow register
    function automatic logic is_reserved_code(input logic [2:0] code);
        return !(code == CODE_AUX || code == CODE_PWR || code == CODE_TEST || code == CODE_MISC);
    endfunction
endpackage
`default_nettype wire

// *** test_path_if.sv ***
// control carrier from the register bank to the line data path
`timescale 1ns/1ps
`default_nettype none
interface test_path_if;
    logic loopback_en;
    logic same_pair_txrx_test;
    modport ctrl (output loopback_en, output same_pair_txrx_test);
    modport path (input loopback_en, input same_pair_txrx_test);
endinterface
`default_nettype wire

// *** line_loop_path.sv ***
// line-side loopback and same-pair steering of the data path
`timescale 1ns/1ps
`default_nettype none
module line_loop_path (
    input  wire logic                              core_clk,
    input  wire logic                              rst_n,
    test_path_if.path                              ctl,
    input  wire logic [copper_test_pkg::DATA_W-1:0] mdi_rx_data,
    input  wire logic                              mdi_rx_valid,
    input  wire logic [copper_test_pkg::DATA_W-1:0] pcs_tx_data,
    input  wire logic                              pcs_tx_valid,
    output logic      [copper_test_pkg::DATA_W-1:0] mdi_tx_data,
    output logic                                   mdi_tx_valid,
    output logic      [copper_test_pkg::DATA_W-1:0] pcs_rx_data,
    output logic                                   pcs_rx_valid
);
    logic [copper_test_pkg::DATA_W-1:0] tx_data_q, tx_data_d;
    logic [copper_test_pkg::DATA_W-1:0] rx_data_q, rx_data_d;
    logic                               tx_valid_q, tx_valid_d;
    logic                               rx_valid_q, rx_valid_d;
    logic [copper_test_pkg::DATA_W-1:0] rcv_data;
    logic                               rcv_valid;

    always_comb
    begin
        // receiver hears its own transmitter when pairs are shared
        rcv_data  = ctl.same_pair_txrx_test ? tx_data_q : mdi_rx_data;
        rcv_valid = ctl.same_pair_txrx_test ? tx_valid_q : mdi_rx_valid;
        rx_data_d  = rcv_data;
        rx_valid_d = rcv_valid;
        // received traffic goes back out the line when looped
        tx_data_d  = ctl.loopback_en ? rcv_data : pcs_tx_data;
        tx_valid_d = ctl.loopback_en ? rcv_valid : pcs_tx_valid;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_data_q  <= '0;
            tx_valid_q <= 1'b0;
            rx_data_q  <= '0;
            rx_valid_q <= 1'b0;
        end
        else
        begin
            tx_data_q  <= tx_data_d;
            tx_valid_q <= tx_valid_d;
            rx_data_q  <= rx_data_d;
            rx_valid_q <= rx_valid_d;
        end
    end

    assign mdi_tx_data  = tx_data_q;
    assign mdi_tx_valid = tx_valid_q;
    assign pcs_rx_data  = rx_data_q;
    assign pcs_rx_valid = rx_valid_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    AST_LOOP_RETURNS_RX: assert property (
        ctl.loopback_en && !ctl.same_pair_txrx_test
        |=> mdi_tx_valid == $past(mdi_rx_valid) && mdi_tx_data == $past(mdi_rx_data))
        else $error("looped line transmit does not carry received data");
    AST_NO_LOOP_USES_PCS: assert property (
        !ctl.loopback_en |=> mdi_tx_valid == $past(pcs_tx_valid) && mdi_tx_data == $past(pcs_tx_data))
        else $error("unlooped line transmit does not carry pcs data");
    AST_SAME_PAIR_HEARS_TX: assert property (
        ctl.same_pair_txrx_test |=> pcs_rx_data == $past(mdi_tx_data) && pcs_rx_valid == $past(mdi_tx_valid))
        else $error("shared pair receiver does not see own transmit");
    AST_NORMAL_PAIR_HEARS_LINE: assert property (
        !ctl.same_pair_txrx_test |=> pcs_rx_data == $past(mdi_rx_data))
        else $error("normal receiver does not see line data");

    COV_LOOP_TRAFFIC: cover property (ctl.loopback_en && mdi_rx_valid ##1 mdi_tx_valid);
    COV_SAME_PAIR:    cover property (ctl.same_pair_txrx_test && mdi_tx_valid ##1 pcs_rx_valid);
endmodule
`default_nettype wire

// *** copper_test_shadow_register.sv ***
// copper test shadow register with read selector and line test controls
//
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module copper_test_shadow_register (
    input  wire logic                              core_clk,
    input  wire logic                              rst_n,
    input  wire logic [15:0]                       reg_addr,
    input  wire logic [15:0]                       reg_wdata,
    input  wire logic                              reg_wr,
    input  wire logic                              reg_rd,
    output logic      [15:0]                       reg_rdata,
    output logic                                   line_loopback_en,
    output logic                                   same_pair_txrx_test,
    input  wire logic [copper_test_pkg::DATA_W-1:0] mdi_rx_data,
    input  wire logic                              mdi_rx_valid,
    input  wire logic [copper_test_pkg::DATA_W-1:0] pcs_tx_data,
    input  wire logic                              pcs_tx_valid,
    output logic      [copper_test_pkg::DATA_W-1:0] mdi_tx_data,
    output logic                                   mdi_tx_valid,
    output logic      [copper_test_pkg::DATA_W-1:0] pcs_rx_data,
    output logic                                   pcs_rx_valid
);
    logic [12:0] test_q, test_d;
    logic [2:0]  rsel_q, rsel_d;
    logic [15:0] rdata_q, rdata_d;
    logic        hit;
    logic [2:0]  wr_code;

    test_path_if ctl_if ();

    // shadow contents as seen through a given selector code
    function automatic logic [15:0] shadow_view(input logic [2:0]  code,
                                                input logic [12:0] test,
                                                input logic [2:0]  rsel);
        logic [15:0] v;
        v = {copper_test_pkg::OTHER_UPPER, code};
        if (code == copper_test_pkg::CODE_TEST)
            v = {test, copper_test_pkg::CODE_TEST};
        else if (code == copper_test_pkg::CODE_MISC)
            v = {1'b0, rsel, copper_test_pkg::MISC_MID_READ, copper_test_pkg::CODE_MISC};
        return v;
    endfunction

    assign hit     = reg_addr == copper_test_pkg::SHADOW_ADDR;
    assign wr_code = reg_wdata[copper_test_pkg::SEL_MSB:copper_test_pkg::SEL_LSB];

    // write decode: low bits steer the upper thirteen
    always_comb
    begin
        test_d = test_q;
        rsel_d = rsel_q;
        if (reg_wr && hit && !copper_test_pkg::is_reserved_code(wr_code))
        begin
            case (wr_code)
                copper_test_pkg::CODE_TEST:
                begin
                    test_d = reg_wdata[copper_test_pkg::TEST_MSB:copper_test_pkg::TEST_LSB];
                end
                copper_test_pkg::CODE_MISC:
                begin
                    // read selector is written regardless of the enable bit
                    rsel_d = reg_wdata[copper_test_pkg::RSEL_MSB:copper_test_pkg::RSEL_LSB];
                end
                default:
                begin
                    test_d = test_q;
                    rsel_d = rsel_q;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            test_q <= copper_test_pkg::TEST_RESET;
            rsel_q <= copper_test_pkg::RSEL_RESET;
        end
        else
        begin
            test_q <= test_d;
            rsel_q <= rsel_d;
        end
    end

    // read answer stands one cycle after the strobe only
    always_comb
    begin
        rdata_d = copper_test_pkg::UNMAPPED_READ;
        if (reg_rd && hit)
            rdata_d = shadow_view(rsel_q, test_q, rsel_q);
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
            rdata_q <= copper_test_pkg::UNMAPPED_READ;
        else
            rdata_q <= rdata_d;
    end

    assign reg_rdata           = rdata_q;
    assign line_loopback_en    = test_q[copper_test_pkg::LOOP_BIT - copper_test_pkg::TEST_LSB];
    assign same_pair_txrx_test = test_q[copper_test_pkg::SWAP_BIT - copper_test_pkg::TEST_LSB];
    assign ctl_if.loopback_en         = line_loopback_en;
    assign ctl_if.same_pair_txrx_test = same_pair_txrx_test;

    line_loop_path u_path (
        .core_clk     (core_clk),
        .rst_n        (rst_n),
        .ctl          (ctl_if.path),
        .mdi_rx_data  (mdi_rx_data),
        .mdi_rx_valid (mdi_rx_valid),
        .pcs_tx_data  (pcs_tx_data),
        .pcs_tx_valid (pcs_tx_valid),
        .mdi_tx_data  (mdi_tx_data),
        .mdi_tx_valid (mdi_tx_valid),
        .pcs_rx_data  (pcs_rx_data),
        .pcs_rx_valid (pcs_rx_valid)
    );

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    AST_TEST_WRITE_TAKES_UPPER: assert property (
        reg_wr && hit && wr_code == copper_test_pkg::CODE_TEST
        |=> line_loopback_en == $past(reg_wdata[15]) && same_pair_txrx_test == $past(reg_wdata[4]))
        else $error("test write did not land in test bits");
    AST_OTHER_CODES_SPARE_TEST: assert property (
        reg_wr && hit && wr_code != copper_test_pkg::CODE_TEST |=> $stable(test_q))
        else $error("non-test code changed the test register");
    AST_TEST_READ_CODE: assert property (
        reg_rd && hit && rsel_q == copper_test_pkg::CODE_TEST
        |=> reg_rdata[2:0] == 3'h4 && reg_rdata[15] == $past(line_loopback_en))
        else $error("test read lacks its selector or loopback bit");
    AST_READ_BY_SELECTOR: assert property (
        reg_wr && hit && wr_code == copper_test_pkg::CODE_MISC ##1 reg_rd && hit
        |=> reg_rdata[2:0] == $past(reg_wdata[14:12], 2))
        else $error("read did not follow the written read selector");
    AST_RESERVED_CODE_IGNORED: assert property (
        reg_wr && copper_test_pkg::is_reserved_code(wr_code) |=> $stable(test_q) && $stable(rsel_q))
        else $error("reserved selector code changed a shadow");
    AST_READ_ONE_CYCLE: assert property (
        !reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data present without a read");
    AST_LOOP_HOLDS: assert property (
        !(reg_wr && hit) |=> $stable(line_loopback_en))
        else $error("loopback enable moved without a write");

    // write side
    AST_TEST_WRITE_ALL_BITS: assert property (
        reg_wr && hit && wr_code == copper_test_pkg::CODE_TEST
        |=> test_q == $past(reg_wdata[copper_test_pkg::TEST_MSB:copper_test_pkg::TEST_LSB]))
        else $error("test write did not store all upper bits");
    AST_MISC_WRITE_SETS_RSEL: assert property (
        reg_wr && hit && wr_code == copper_test_pkg::CODE_MISC
        |=> rsel_q == $past(reg_wdata[copper_test_pkg::RSEL_MSB:copper_test_pkg::RSEL_LSB]))
        else $error("misc write did not store the read selector");
    AST_OTHER_CODES_SPARE_RSEL: assert property (
        reg_wr && hit && wr_code != copper_test_pkg::CODE_MISC |=> $stable(rsel_q))
        else $error("non-misc code changed the read selector");
    AST_AUX_PWR_NO_EFFECT: assert property (
        reg_wr && hit && (wr_code == copper_test_pkg::CODE_AUX || wr_code == copper_test_pkg::CODE_PWR)
        |=> $stable(test_q) && $stable(rsel_q))
        else $error("unimplemented shadow write changed stored state");
    AST_UNMAPPED_WRITE_IGNORED: assert property (
        reg_wr && !hit |=> $stable(test_q) && $stable(rsel_q))
        else $error("write to another address changed a shadow");
    AST_SWAP_HOLDS: assert property (
        !(reg_wr && hit) |=> $stable(same_pair_txrx_test))
        else $error("pair swap moved without a write");
    AST_RSEL_HOLDS: assert property (
        !(reg_wr && hit) |=> $stable(rsel_q))
        else $error("read selector moved without a write");

    // read side
    AST_READ_CODE_MATCHES_SELECTOR: assert property (
        reg_rd && hit |=> reg_rdata[copper_test_pkg::SEL_MSB:copper_test_pkg::SEL_LSB] == $past(rsel_q))
        else $error("read code field does not match the read selector");
    AST_TEST_READ_FULL: assert property (
        reg_rd && hit && rsel_q == copper_test_pkg::CODE_TEST
        |=> reg_rdata[copper_test_pkg::TEST_MSB:copper_test_pkg::TEST_LSB] == $past(test_q))
        else $error("test read does not return stored upper bits");
    AST_MISC_READ_VIEW: assert property (
        reg_rd && hit && rsel_q == copper_test_pkg::CODE_MISC
        |=> reg_rdata == {1'b0, $past(rsel_q), copper_test_pkg::MISC_MID_READ, copper_test_pkg::CODE_MISC})
        else $error("misc read view is wrong");
    AST_OTHER_READ_VIEW: assert property (
        reg_rd && hit && rsel_q != copper_test_pkg::CODE_TEST && rsel_q != copper_test_pkg::CODE_MISC
        |=> reg_rdata == {copper_test_pkg::OTHER_UPPER, $past(rsel_q)})
        else $error("plain shadow read view is wrong");
    AST_UNMAPPED_READ_ZERO: assert property (
        reg_rd && !hit |=> reg_rdata == copper_test_pkg::UNMAPPED_READ)
        else $error("read of another address returned data");
    AST_TEST_WRITE_THEN_READ: assert property (
        reg_wr && hit && wr_code == copper_test_pkg::CODE_TEST
        ##1 reg_rd && hit && rsel_q == copper_test_pkg::CODE_TEST
        |=> reg_rdata[copper_test_pkg::TEST_MSB:copper_test_pkg::TEST_LSB]
            == $past(reg_wdata[copper_test_pkg::TEST_MSB:copper_test_pkg::TEST_LSB], 2))
        else $error("read right after a test write missed the new value");

    // reset
    AST_RESET_CLEARS: assert property (@(posedge core_clk) disable iff (1'b0)
        !rst_n |-> !line_loopback_en && !same_pair_txrx_test && rsel_q == copper_test_pkg::RSEL_RESET
                   && !mdi_tx_valid && !pcs_rx_valid
                   && reg_rdata == copper_test_pkg::UNMAPPED_READ)
        else $error("state not cleared while reset is held");

    COV_LOOP_ON:   cover property (reg_wr && hit && wr_code == 3'h4 && reg_wdata[15]);
    COV_SWAP_ON:   cover property (reg_wr && hit && wr_code == 3'h4 && reg_wdata[4]);
    COV_TEST_READ: cover property (reg_rd && hit && rsel_q == 3'h4);
endmodule
`default_nettype wire

// *** tb_top.sv ***
// self-checking bench for the copper test shadow register
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam logic [15:0] ADDR = copper_test_pkg::SHADOW_ADDR;
    logic        core_clk;
    logic        rst_n;
    logic [15:0] reg_addr;
    logic [15:0] reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [15:0] reg_rdata;
    logic        line_loopback_en;
    logic        same_pair_txrx_test;
    logic [7:0]  mdi_rx_data;
    logic        mdi_rx_valid;
    logic [7:0]  pcs_tx_data;
    logic        pcs_tx_valid;
    logic [7:0]  mdi_tx_data;
    logic        mdi_tx_valid;
    logic [7:0]  pcs_rx_data;
    logic        pcs_rx_valid;
    int          error_cnt;
    int          total_checks;
    int          cycle_cnt;
    logic [12:0] tm;
    logic [2:0]  rs;
    logic        pend;
    logic [15:0] pend_exp;
    logic [8:0]  etx;
    logic [8:0]  erx;

    copper_test_shadow_register copper_test_shadow_register_i (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .line_loopback_en(line_loopback_en),
        .same_pair_txrx_test(same_pair_txrx_test), .mdi_rx_data(mdi_rx_data), .mdi_rx_valid(mdi_rx_valid),
        .pcs_tx_data(pcs_tx_data), .pcs_tx_valid(pcs_tx_valid), .mdi_tx_data(mdi_tx_data),
        .mdi_tx_valid(mdi_tx_valid), .pcs_rx_data(pcs_rx_data), .pcs_rx_valid(pcs_rx_valid)
    );

    task automatic chk_reg(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_line(input string n, input logic [8:0] e, input logic [8:0] g);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_bit(input string n, input logic e, input logic g);
        total_checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("wrong value %s expected %b seen %b", n, e, g);
        end
    endtask

    // read view of the shared address for the current read selector
    function automatic logic [15:0] view();
        case (rs)
            copper_test_pkg::CODE_TEST: return {tm, copper_test_pkg::CODE_TEST};
            copper_test_pkg::CODE_MISC: return {1'h0, rs, 9'h000, copper_test_pkg::CODE_MISC};
            default: return {13'h0000, rs};
        endcase
    endfunction

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // one bus cycle plus one random line sample, checking the previous cycle's results
    task automatic cyc(input logic w, input logic r, input logic [15:0] a, input logic [15:0] d);
        logic [8:0] rx;
        logic [8:0] tx;
        logic [8:0] src;
        rx = 9'($urandom);
        tx = 9'($urandom);
        // software keeps reserved test bits as last written
        if (w && a == ADDR && d[2:0] == copper_test_pkg::CODE_TEST)
            d = {d[15], tm[11:2], d[4], tm[0], d[2:0]};
        @(posedge core_clk);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        {mdi_rx_valid, mdi_rx_data} <= rx;
        {pcs_tx_valid, pcs_tx_data} <= tx;
        @(negedge core_clk);
        chk_reg("reg_rdata", pend ? pend_exp : 16'h0000, reg_rdata);
        chk_bit("line_loopback_en", tm[12], line_loopback_en);
        chk_bit("same_pair_txrx_test", tm[1], same_pair_txrx_test);
        chk_line("mdi_tx", etx, {mdi_tx_valid, mdi_tx_data});
        chk_line("pcs_rx", erx, {pcs_rx_valid, pcs_rx_data});
        src = tm[1] ? etx : rx;
        erx = src;
        etx = tm[12] ? src : tx;
        pend = r;
        pend_exp = (a == ADDR) ? view() : 16'h0000;
        if (w && a == ADDR && d[2:0] == copper_test_pkg::CODE_TEST)
            tm = d[15:3];
        if (w && a == ADDR && d[2:0] == copper_test_pkg::CODE_MISC)
            rs = d[14:12];
    endtask

    initial
    begin
        core_clk = 1'h0;
        forever #12.5 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        cycle_cnt <= cycle_cnt + 1;
        if (cycle_cnt == 3000)
        begin
            error_cnt++;
            summarize();
        end
    end

    initial
    begin
        int op;
        logic [15:0] d;
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {mdi_rx_valid, mdi_rx_data, pcs_tx_valid, pcs_tx_data} = '0;
        {error_cnt, total_checks, cycle_cnt} = '0;
        {tm, rs, pend, pend_exp, etx, erx} = '0;
        void'($urandom(32'h2549FC7E));
        repeat (20) @(posedge core_clk);
        rst_n <= 1'h1;
        cyc(1'h0, 1'h1, ADDR, 16'h0000);
        cyc(1'h1, 1'h0, ADDR, 16'h4007);
        cyc(1'h0, 1'h1, ADDR, 16'h0000);
        cyc(1'h1, 1'h0, ADDR, 16'h8014);
        cyc(1'h0, 1'h1, ADDR, 16'h0000);
        $display("test reset_and_walk done");
        for (int c = 0; c < 8; c++)
        begin
            cyc(1'h1, 1'h0, ADDR, {13'($urandom), 3'(c)});
            cyc(1'h0, 1'h1, ADDR, 16'h0000);
        end
        $display("test selector_codes done");
        cyc(1'h1, 1'h0, ADDR, 16'h4007);
        for (int m = 0; m < 4; m++)
        begin
            cyc(1'h1, 1'h0, ADDR, {m[1], 10'h000, m[0], 1'h0, copper_test_pkg::CODE_TEST});
            repeat (15) cyc(1'h0, 1'h0, 16'h0000, 16'h0000);
        end
        $display("test line_modes done");
        repeat (300)
        begin
            op = $urandom_range(3);
            d = 16'($urandom);
            case (op)
                0: cyc(1'h1, 1'h0, ADDR, d);
                1: cyc(1'h1, 1'h0, 16'($urandom), d);
                2: cyc(1'h0, 1'h1, ADDR, d);
                default: cyc(1'h0, 1'h1, 16'($urandom), d);
            endcase
        end
        repeat (2) cyc(1'h0, 1'h0, 16'h0000, 16'h0000);
        $display("test random_traffic done");
        summarize();
    end
endmodule
`default_nettype wire
